// ---- logic/abtc_consts.svh ----
// Register offsets, field positions, reset values and link codes of the codec.
// Included by the package; the codec uses its macros; holds definitions only.
`ifndef ABTC_CONSTS_SVH
`define ABTC_CONSTS_SVH

`define ABTC_OFF_CTRL     8'h00
`define ABTC_OFF_NULLS    8'h04
`define ABTC_OFF_LEN      8'h08
`define ABTC_OFF_STAT     8'h0C
`define ABTC_OFF_MADDR    8'h10
`define ABTC_OFF_MDATA    8'h14

`define ABTC_CTRL_GO      0
`define ABTC_CTRL_DIR     1
`define ABTC_CTRL_SEL_LO  2
`define ABTC_CTRL_W4      4
`define ABTC_CTRL_MODEM   5
`define ABTC_CTRL_PAUSE   6
`define ABTC_CTRL_FMT_LO  8
`define ABTC_STAT_DONE    2

`define ABTC_FMT_RST      8'h01
`define ABTC_NULLS_RST    8'h32
`define ABTC_NULLS_SKIP   8'hFF
`define ABTC_FMT_NOLEAD   8'h89

`define ABTC_CH_XON       8'h11
`define ABTC_CH_XOFF      8'h13
`define ABTC_CH_OBEGIN    8'h12
`define ABTC_CH_OEND      8'h14
`define ABTC_CH_STX       8'h02
`define ABTC_CH_ETX       8'h03
`define ABTC_CH_NUL       8'h00
`define ABTC_CH_OPEN      8'h42
`define ABTC_CH_CLOSE     8'h46
`define ABTC_CH_ABORT     8'h45
`define ABTC_CH_SPACE     8'h20
`define ABTC_CH_CR        8'h0D
`define ABTC_CH_LF        8'h0A

`endif

// ---- logic/abtc_pkg.sv ----
// Types and character functions of the codec.
// Assumes the constants header is on the include path.
`default_nettype none
`include "abtc_consts.svh"
package abtc_pkg;
    typedef enum logic [12:0] {
        T_IDLE  = 13'h0001, T_LEAD  = 13'h0002, T_BEGM = 13'h0004, T_STX  = 13'h0008,
        T_OPEN  = 13'h0010, T_BITS  = 13'h0020, T_CLOSE = 13'h0040, T_SEP = 13'h0080,
        T_CR    = 13'h0100, T_LF    = 13'h0200, T_ETX  = 13'h0400, T_TRAIL = 13'h0800,
        T_ENDM  = 13'h1000
    } abtc_tx_state_t;

    typedef enum logic [3:0] {
        R_IDLE = 4'h1, R_WSTX = 4'h2, R_GAP = 4'h4, R_BITS = 4'h8
    } abtc_rx_state_t;

    // Character set: 0 none, 1 N/P, 2 L/H, 3 0/1
    function automatic logic [1:0] abtc_set(input logic [7:0] fmt);
        unique case (fmt)
            8'h01, 8'h05: abtc_set = 2'h1;
            8'h02, 8'h06: abtc_set = 2'h2;
            8'h03, 8'h07: abtc_set = 2'h3;
            default:      abtc_set = 2'h0;
        endcase
    endfunction

    function automatic logic abtc_has_stx(input logic [7:0] fmt);
        abtc_has_stx = (fmt == 8'h01) || (fmt == 8'h02) || (fmt == 8'h03);
    endfunction

    function automatic logic [7:0] abtc_bit_char(input logic [1:0] cs, input logic b);
        unique case (cs)
            2'h1:    abtc_bit_char = b ? 8'h50 : 8'h4E;
            2'h2:    abtc_bit_char = b ? 8'h48 : 8'h4C;
            default: abtc_bit_char = b ? 8'h31 : 8'h30;
        endcase
    endfunction

    // Returns {valid, bit} for a received character
    function automatic logic [1:0] abtc_char_bit(input logic [1:0] cs, input logic [7:0] ch);
        abtc_char_bit = 2'h0;
        if (ch == abtc_bit_char(cs, 1'b1)) begin
            abtc_char_bit = 2'h3;
        end else if (ch == abtc_bit_char(cs, 1'b0)) begin
            abtc_char_bit = 2'h2;
        end
    endfunction
endpackage
`default_nettype wire

// ---- logic/abtc_codec.sv ----
// Binary text transfer codec: memory image to and from a byte link, APB registers.
// Assumes one 25 MHz clock, link bytes synchronous to it, APB master on the same clock.
//
// Contract
// - Receive, selector 0/2: XOFF pauses, XON resumes
// - Transmit, selector 0: stop on XOFF, resume XON
// - Receive, selector 1: XON ready, XOFF full/end
// - Transmit, selector 1: begin marker, pause, end marker
// - Transmit, selector 2: wait for first XON
// - XON is 0x11, XOFF is 0x13
// - Begin marker 0x12, end marker 0x14
// - Modem-line flow on after reset, else characters
// - Character flow control is always honoured
// - Fifty nulls lead and trail, except format 89
// - Null count FF omits leader and trailer
// - Codes 01/02/03 use N/P, L/H, 0/1
// - Each byte framed by B and F
// - Received bytes stored from first address upward
// - Characters between F and B ignored
// - Four-bit width sends four bit characters
// - Start code 0x02, end code 0x03
// - Codes 05/06/07 omit start and end codes
// - E inside a byte discards that byte only
// - Four bytes per line, spaces between bytes
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module abtc_codec
    import abtc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    output logic      [7:0]  tx_data_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    input  wire logic        cts_i,
    input  wire logic        cts_conn_i,
    output logic             dtr_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and state

    logic [7:0]     mem_r [0:255];
    logic           dir_r;
    logic [1:0]     sel_r;
    logic           w4_r;
    logic           modem_r;
    logic           pause_r;
    logic [7:0]     fmt_r;
    logic [7:0]     nulls_r;
    logic [15:0]    len_r;
    logic [7:0]     maddr_r;
    logic           done_r;
    logic [7:0]     err_r;
    logic [15:0]    rxcnt_r;
    logic           xoff_r;
    logic           fc_pend_r;
    logic           fc_off_r;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;
    logic [7:0]     tx_data_r;
    logic           tx_valid_r;
    logic           dtr_r;

    abtc_tx_state_t tst_r;
    abtc_tx_state_t tst_nxt;
    abtc_rx_state_t rst_r;
    logic [7:0]     cnt_r;
    logic [2:0]     bidx_r;
    logic [1:0]     line_r;
    logic [7:0]     rd_ptr_r;
    logic [15:0]    remain_r;
    logic [7:0]     wr_ptr_r;
    logic [7:0]     acc_r;
    logic [3:0]     bcnt_r;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic           acc_ph;
    logic           wr_en;
    logic           go;
    logic           idle;
    logic [1:0]     cset;
    logic           has_stx;
    logic           nulls_on;
    logic [2:0]     top_bit;
    logic [3:0]     width;
    logic           mapped;

    assign acc_ph   = psel_i && penable_i;
    assign wr_en    = acc_ph && pready_r && pwrite_i;
    assign idle     = (tst_r == T_IDLE) && (rst_r == R_IDLE);
    assign go       = wr_en && (paddr_i == `ABTC_OFF_CTRL) && pwdata_i[`ABTC_CTRL_GO] && idle;
    assign cset     = abtc_set(fmt_r);
    assign has_stx  = abtc_has_stx(fmt_r);
    assign nulls_on = (nulls_r != `ABTC_NULLS_SKIP) && (fmt_r != `ABTC_FMT_NOLEAD);
    assign top_bit  = w4_r ? 3'h3 : 3'h7;
    assign width    = w4_r ? 4'h4 : 4'h8;
    assign mapped   = (paddr_i <= `ABTC_OFF_MDATA) && (paddr_i[1:0] == 2'h0);

    // Answer one cycle into the access phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc_ph && !pready_r;
            pslverr_r <= acc_ph && !pready_r && !mapped;
            if (acc_ph && !pready_r && !pwrite_i) begin
                unique case (paddr_i)
                    `ABTC_OFF_CTRL:  prdata_r <= {16'h0000, fmt_r, 1'b0, pause_r, modem_r,
                                                  w4_r, sel_r, dir_r, 1'b0};
                    `ABTC_OFF_NULLS: prdata_r <= {24'h000000, nulls_r};
                    `ABTC_OFF_LEN:   prdata_r <= {16'h0000, len_r};
                    `ABTC_OFF_STAT:  prdata_r <= {rxcnt_r, err_r, 4'h0, xoff_r, done_r,
                                                  (rst_r != R_IDLE), (tst_r != T_IDLE)};
                    `ABTC_OFF_MADDR: prdata_r <= {24'h000000, maddr_r};
                    `ABTC_OFF_MDATA: prdata_r <= {24'h000000, mem_r[maddr_r]};
                    default:         prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration, locked while a transfer runs except pause
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_r   <= 1'b0;
            sel_r   <= 2'h0;
            w4_r    <= 1'b0;
            modem_r <= 1'b1;
            pause_r <= 1'b0;
            fmt_r   <= `ABTC_FMT_RST;
            nulls_r <= `ABTC_NULLS_RST;
            len_r   <= 16'h0000;
        end else if (wr_en) begin
            if (paddr_i == `ABTC_OFF_CTRL) begin
                pause_r <= pwdata_i[`ABTC_CTRL_PAUSE];
                if (idle) begin
                    dir_r   <= pwdata_i[`ABTC_CTRL_DIR];
                    sel_r   <= pwdata_i[`ABTC_CTRL_SEL_LO +: 2];
                    w4_r    <= pwdata_i[`ABTC_CTRL_W4];
                    modem_r <= pwdata_i[`ABTC_CTRL_MODEM];
                    fmt_r   <= pwdata_i[`ABTC_CTRL_FMT_LO +: 8];
                end
            end
            if (paddr_i == `ABTC_OFF_NULLS && idle) begin
                nulls_r <= pwdata_i[7:0];
            end
            if (paddr_i == `ABTC_OFF_LEN && idle) begin
                len_r <= pwdata_i[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit sequencer

    logic       can_load;
    logic       hold;
    logic       t_emit;
    logic [7:0] t_ch;
    logic       t_step;
    logic       rx_done;
    logic       rx_in_tx;

    assign can_load = !tx_valid_r || tx_ready_i;
    assign hold     = xoff_r || (modem_r && cts_conn_i && !cts_i);
    assign t_step   = (tst_r != T_IDLE) && (!t_emit || (can_load && !hold));
    assign rx_in_tx = rx_valid_i && (tst_r != T_IDLE);

    always_comb begin
        t_emit  = 1'b1;
        t_ch    = `ABTC_CH_NUL;
        tst_nxt = tst_r;
        unique case (tst_r)
            T_IDLE: begin
                t_emit = 1'b0;
                if (go && pwdata_i[`ABTC_CTRL_DIR]) begin
                    tst_nxt = T_LEAD;
                end
            end
            T_LEAD, T_TRAIL: begin
                t_emit = nulls_on && (cnt_r != nulls_r);
                if (!t_emit) begin
                    tst_nxt = (tst_r == T_LEAD) ? T_BEGM : T_ENDM;
                end
            end
            T_BEGM: begin
                t_emit  = (sel_r == 2'h1);
                t_ch    = `ABTC_CH_OBEGIN;
                tst_nxt = T_STX;
            end
            T_STX: begin
                t_emit  = has_stx;
                t_ch    = `ABTC_CH_STX;
                tst_nxt = (remain_r == 16'h0000) ? T_ETX : T_OPEN;
            end
            T_OPEN: begin
                t_ch    = `ABTC_CH_OPEN;
                tst_nxt = T_BITS;
            end
            T_BITS: begin
                t_ch = abtc_bit_char(cset, mem_r[rd_ptr_r][bidx_r]);
                if (bidx_r == 3'h0) begin
                    tst_nxt = T_CLOSE;
                end
            end
            T_CLOSE: begin
                t_ch = `ABTC_CH_CLOSE;
                if (remain_r == 16'h0001) begin
                    tst_nxt = T_ETX;
                end else if (line_r == 2'h3) begin
                    tst_nxt = T_CR;
                end else begin
                    tst_nxt = T_SEP;
                end
            end
            T_SEP: begin
                t_ch    = `ABTC_CH_SPACE;
                tst_nxt = T_OPEN;
            end
            T_CR: begin
                t_ch    = `ABTC_CH_CR;
                tst_nxt = T_LF;
            end
            T_LF: begin
                t_ch    = `ABTC_CH_LF;
                tst_nxt = T_OPEN;
            end
            T_ETX: begin
                t_emit  = has_stx;
                t_ch    = `ABTC_CH_ETX;
                tst_nxt = T_TRAIL;
            end
            T_ENDM: begin
                t_emit  = (sel_r == 2'h1);
                t_ch    = `ABTC_CH_OEND;
                tst_nxt = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tst_r <= T_IDLE;
        end else if (tst_r == T_IDLE || t_step) begin
            tst_r <= tst_nxt;
        end
    end

    // Counters of the transmit walk
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r    <= 8'h00;
            bidx_r   <= 3'h0;
            line_r   <= 2'h0;
            rd_ptr_r <= 8'h00;
            remain_r <= 16'h0000;
        end else if (tst_r == T_IDLE) begin
            cnt_r    <= 8'h00;
            line_r   <= 2'h0;
            rd_ptr_r <= 8'h00;
            remain_r <= len_r;
            if (go) begin
                remain_r <= pwdata_i[`ABTC_CTRL_DIR] ? len_r : 16'h0000;
            end
        end else if (t_step) begin
            if ((tst_r == T_LEAD || tst_r == T_TRAIL) && t_emit) begin
                cnt_r <= cnt_r + 8'h01;
            end
            if (tst_r == T_ETX) begin
                cnt_r <= 8'h00;
            end
            if (tst_r == T_OPEN) begin
                bidx_r <= top_bit;
            end
            if (tst_r == T_BITS) begin
                bidx_r <= bidx_r - 3'h1;
            end
            if (tst_r == T_CLOSE) begin
                rd_ptr_r <= rd_ptr_r + 8'h01;
                remain_r <= remain_r - 16'h0001;
                line_r   <= line_r + 2'h1;
            end
        end
    end

    // Flow state from host characters while sending
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xoff_r <= 1'b0;
        end else if (go) begin
            xoff_r <= pwdata_i[`ABTC_CTRL_SEL_LO +: 2] == 2'h2;
        end else if (rx_in_tx && rx_data_i == `ABTC_CH_XOFF) begin
            xoff_r <= 1'b1;
        end else if (rx_in_tx && rx_data_i == `ABTC_CH_XON) begin
            xoff_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flow characters while receiving

    logic pause_q;
    logic rx_busy;
    logic rx_start;
    logic fc_set;
    logic fc_set_off;

    assign rx_busy  = (rst_r != R_IDLE);
    assign rx_start = go && !pwdata_i[`ABTC_CTRL_DIR];

    always_comb begin
        fc_set     = 1'b0;
        fc_set_off = 1'b0;
        if (rx_done && sel_r == 2'h1) begin
            fc_set     = 1'b1;
            fc_set_off = 1'b1;
        end else if (rx_busy && pause_r && !pause_q) begin
            fc_set     = 1'b1;
            fc_set_off = 1'b1;
        end else if (rx_busy && !pause_r && pause_q) begin
            fc_set = 1'b1;
        end else if (rx_start && pwdata_i[`ABTC_CTRL_SEL_LO +: 2] == 2'h1) begin
            fc_set = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pause_q   <= 1'b0;
            fc_pend_r <= 1'b0;
            fc_off_r  <= 1'b0;
        end else begin
            pause_q <= pause_r;
            if (fc_set) begin
                fc_pend_r <= 1'b1;
                fc_off_r  <= fc_set_off;
            end else if (fc_pend_r && tst_r == T_IDLE && can_load) begin
                fc_pend_r <= 1'b0;
            end
        end
    end

    // Byte output stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_valid_r <= 1'b0;
            tx_data_r  <= 8'h00;
            dtr_r      <= 1'b0;
        end else begin
            dtr_r <= modem_r && rx_busy && !pause_r;
            if (t_step && t_emit) begin
                tx_valid_r <= 1'b1;
                tx_data_r  <= t_ch;
            end else if (fc_pend_r && tst_r == T_IDLE && can_load) begin
                tx_valid_r <= 1'b1;
                tx_data_r  <= fc_off_r ? `ABTC_CH_XOFF : `ABTC_CH_XON;
            end else if (tx_ready_i) begin
                tx_valid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive decoder

    logic [1:0] cb;
    logic       rx_on;
    logic       rx_wr;

    assign cb      = abtc_char_bit(cset, rx_data_i);
    assign rx_on   = rx_valid_i && rx_busy;
    assign rx_wr   = rx_on && rst_r == R_BITS && rx_data_i == `ABTC_CH_CLOSE && bcnt_r == width;
    assign rx_done = (rx_on && rst_r == R_GAP && has_stx && rx_data_i == `ABTC_CH_ETX)
                     || (rx_wr && len_r != 16'h0000 && rxcnt_r + 16'h0001 == len_r);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_r    <= R_IDLE;
            wr_ptr_r <= 8'h00;
            rxcnt_r  <= 16'h0000;
            acc_r    <= 8'h00;
            bcnt_r   <= 4'h0;
            err_r    <= 8'h00;
        end else if (rx_start) begin
            rst_r    <= abtc_has_stx(pwdata_i[`ABTC_CTRL_FMT_LO +: 8]) ? R_WSTX : R_GAP;
            wr_ptr_r <= 8'h00;
            rxcnt_r  <= 16'h0000;
        end else if (rx_done) begin
            rst_r <= R_IDLE;
            if (rx_wr) begin
                rxcnt_r <= rxcnt_r + 16'h0001;
            end
        end else if (rx_on) begin
            unique case (rst_r)
                R_WSTX: begin
                    if (rx_data_i == `ABTC_CH_STX) begin
                        rst_r <= R_GAP;
                    end
                end
                R_GAP: begin
                    if (rx_data_i == `ABTC_CH_OPEN) begin
                        rst_r  <= R_BITS;
                        acc_r  <= 8'h00;
                        bcnt_r <= 4'h0;
                    end
                end
                R_BITS: begin
                    if (cb[1] && bcnt_r != width) begin
                        acc_r  <= {acc_r[6:0], cb[0]};
                        bcnt_r <= bcnt_r + 4'h1;
                    end else if (rx_wr) begin
                        rst_r    <= R_GAP;
                        wr_ptr_r <= wr_ptr_r + 8'h01;
                        rxcnt_r  <= rxcnt_r + 16'h0001;
                    end else begin
                        rst_r <= R_GAP;
                        err_r <= err_r + 8'h01;
                    end
                end
                default: begin
                    rst_r <= R_IDLE;
                end
            endcase
        end
    end

    // Sticky completion flag, set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
        end else if (rx_done || (tst_r == T_ENDM && t_step)) begin
            done_r <= 1'b1;
        end else if (wr_en && paddr_i == `ABTC_OFF_STAT && pwdata_i[`ABTC_STAT_DONE]) begin
            done_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Image memory, decoder write wins over bus write

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            maddr_r <= 8'h00;
        end else if (wr_en && paddr_i == `ABTC_OFF_MADDR) begin
            maddr_r <= pwdata_i[7:0];
        end else if (acc_ph && pready_r && paddr_i == `ABTC_OFF_MDATA) begin
            maddr_r <= maddr_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rx_wr) begin
            mem_r[wr_ptr_r] <= w4_r ? {4'h0, acc_r[3:0]} : acc_r;
        end else if (wr_en && paddr_i == `ABTC_OFF_MDATA) begin
            mem_r[maddr_r] <= pwdata_i[7:0];
        end
    end

    assign prdata_o   = prdata_r;
    assign pready_o   = pready_r;
    assign pslverr_o  = pslverr_r;
    assign tx_data_o  = tx_data_r;
    assign tx_valid_o = tx_valid_r;
    assign dtr_o      = dtr_r;

endmodule
`default_nettype wire

// ---- tb/abtc_props.sv ----
// Port checker for the transfer codec.
// Assumes it is bound to abtc_codec, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module abtc_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [7:0]  rx_data_i,
    input wire logic        rx_valid_i,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    one_wait_a: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    ready_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    bad_addr_a: assert property (pready_o && (paddr_i > 8'h14 || |paddr_i[1:0]) |-> pslverr_o)
        else $error("no error on unmapped address");
    good_addr_a: assert property (pslverr_o |-> pready_o && (paddr_i > 8'h14 || |paddr_i[1:0]))
        else $error("error on mapped address");
    rdata_hold_a: assert property (!(psel_i && penable_i && !pwrite_i) |=> $stable(prdata_o))
        else $error("read data changed without read");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx byte changed before acceptance");
    xoff_stop_a: assert property (
        rx_valid_i && rx_data_i == 8'h13 ##1 !rx_valid_i [*3] |-> !$rose(tx_valid_o))
        else $error("new tx byte after pause character");
endmodule
bind abtc_codec abtc_props u_props (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .rx_data_i, .rx_valid_i, .tx_data_o, .tx_valid_o, .tx_ready_i);
`default_nettype wire

// ---- tb/abtc_host.sv ----
// Link partner model: takes codec bytes, sends bytes to it.
// Assumes one clock shared with the codec.
`timescale 1ns/1ns
`default_nettype none
module abtc_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output var logic        tx_ready_o,
    output var logic [7:0]  rx_data_o,
    output var logic        rx_valid_o
);
    logic [7:0] got[$];
    int         slow = 0;
    logic       ph = 0;
    initial begin
        tx_ready_o = 0;
        rx_data_o  = 0;
        rx_valid_o = 0;
    end
    // Slow mode refuses every other cycle
    always @(posedge clk_i) begin
        ph <= ~ph;
        tx_ready_o <= slow == 0 || ph;
        if (tx_valid_i && tx_ready_o)
            got.push_back(tx_data_i);
    end
    // One byte pulse, then inverse data so a stale byte is never reused
    task automatic send(input logic [7:0] b);
        rx_data_o  <= b;
        rx_valid_o <= 1;
        @(posedge clk_i);
        rx_data_o  <= ~b;
        rx_valid_o <= 0;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ---- tb/abtc_codec_test.sv ----
// Self-checking bench for the transfer codec.
// Assumes codec, checker and host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module abtc_codec_test;
    typedef struct {logic [7:0] a; logic [31:0] v; logic e;} abtc_row_t;
    logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic        rx_valid_i, tx_valid_o, tx_ready_i, dtr_o, cts_i, cts_conn_i;
    logic [7:0]  paddr_i, rx_data_i, tx_data_o;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [7:0]  exp[$];
    logic [7:0]  dat[5] = '{8'hA5, 8'h3C, 8'h01, 8'h80, 8'hFF};
    int          error_cnt = 0;
    int          checks_done = 0;
    abtc_row_t   rows[6] = '{'{8'h00, 32'h120, 0}, '{8'h04, 32'h32, 0}, '{8'h08, 0, 0},
                             '{8'h0C, 0, 0}, '{8'h18, 0, 1}, '{8'h02, 0, 1}};
    abtc_codec dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .rx_data_i, .rx_valid_i, .tx_data_o, .tx_valid_o,
        .tx_ready_i, .cts_i, .cts_conn_i, .dtr_o);
    abtc_host host (.clk_i, .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic wait_done;
        do apb(0, 8'h0C, 0); while (rd[2] !== 1);
        apb(1, 8'h0C, 4);
    endtask
    function automatic void frame(input logic [7:0] b, input int cs, input int w);
        logic [7:0] one[4] = '{0, 8'h50, 8'h48, 8'h31};
        logic [7:0] zero[4] = '{0, 8'h4E, 8'h4C, 8'h30};
        exp.push_back(8'h42);
        for (int i = w - 1; i >= 0; i--) exp.push_back(b[i] ? one[cs] : zero[cs]);
        exp.push_back(8'h46);
    endfunction
    task automatic cmpq;
        chk(host.got.size(), exp.size());
        foreach (exp[i]) chk(host.got[i], exp[i]);
        host.got.delete();
        exp.delete();
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_i = 0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {cts_i, cts_conn_i, rst_i} = 3'h7;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            chk(rd, rows[i].v);
            chk(err, rows[i].e);
        end
        host.slow = 1;
        apb(1, 8'h10, 0);
        foreach (dat[i]) apb(1, 8'h14, dat[i]);
        apb(1, 8'h04, 8'hFF);
        apb(1, 8'h08, 5);
        apb(1, 8'h00, 32'h0323);
        cts_i <= 0;
        repeat (10) @(posedge clk_i);
        chk(host.got.size(), 0);
        cts_conn_i <= 0;
        exp = {8'h02};
        foreach (dat[i]) begin
            frame(dat[i], 3, 8);
            if (i == 3) exp = {exp, 8'h0D, 8'h0A};
            else if (i < 4) exp.push_back(8'h20);
        end
        exp.push_back(8'h03);
        wait_done;
        cmpq;
        {cts_i, cts_conn_i} <= 2'h3;
        apb(1, 8'h04, 2);
        apb(1, 8'h08, 1);
        apb(1, 8'h00, 32'h0537);
        exp = {8'h00, 8'h00, 8'h12};
        frame(8'hA5, 1, 4);
        exp = {exp, 8'h00, 8'h00, 8'h14};
        wait_done;
        cmpq;
        apb(1, 8'h04, 8'hFF);
        apb(1, 8'h00, 32'h072B);
        repeat (20) @(posedge clk_i);
        chk(host.got.size(), 0);
        host.send(8'h11);
        repeat (4) @(posedge clk_i);
        host.send(8'h13);
        repeat (3) @(posedge clk_i);
        rd = host.got.size();
        repeat (20) @(posedge clk_i);
        chk(host.got.size(), rd);
        host.send(8'h11);
        frame(8'hA5, 3, 8);
        wait_done;
        cmpq;
        apb(1, 8'h08, 0);
        apb(1, 8'h00, 32'h0225);
        exp = {8'h02, 8'h20};
        frame(8'hA5, 2, 8);
        exp = {exp, 8'h0D, 8'h42, 8'h48, 8'h45, 8'h46};
        frame(8'h0F, 2, 8);
        exp.push_back(8'h03);
        @(posedge clk_i);
        chk(dtr_o, 1);
        apb(1, 8'h00, 32'h40);
        apb(1, 8'h00, 0);
        foreach (exp[i]) host.send(exp[i]);
        exp = {8'h11, 8'h13, 8'h11, 8'h13};
        wait_done;
        cmpq;
        apb(1, 8'h10, 0);
        apb(0, 8'h14, 0);
        chk(rd, 8'hA5);
        apb(0, 8'h14, 0);
        chk(rd, 8'h0F);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h20100);
        give_verdict;
    end
endmodule
`default_nettype wire
